/* File: logic/opc_regs.svh */
// constants for the otg port control register block
// assumes a 16-bit command/data port driven by the local processor interface
`ifndef OPC_REGS_SVH
`define OPC_REGS_SVH
`define OPC_CMD_READ       8'h62
`define OPC_CMD_WRITE      8'he2
`define OPC_BIT_SE0_EN     11
`define OPC_BIT_SRP_DET_EN 10
`define OPC_BIT_SRP_SEL    9
`define OPC_BIT_ENG_SEL    8
`define OPC_BIT_PD_DM      7
`define OPC_BIT_PD_DP      6
`define OPC_BIT_AUTO_CONN  5
`define OPC_BIT_LOCAL_DP_PULLUP   4
`define OPC_BIT_SRC_SEL    3
`define OPC_BIT_DISCHRG    2
`define OPC_BIT_CHRG       1
`define OPC_BIT_VBUS_DRIVE_ENABLE   0
`define OPC_WRITE_MASK     16'h0fff
`define OPC_RESET_VALUE    16'h01c0
`define OPC_SE0_TIME_NS    10000
`define OPC_CLK_NS         20
`define OPC_SE0_CYCLES     (`OPC_SE0_TIME_NS / `OPC_CLK_NS)
`endif

/* File: logic/opc_pkg.sv */
// types shared by the otg port control block
// assumes opc_regs.svh for all numeric constants
`default_nettype none
package opc_pkg;
  typedef logic [15:0] opc_word_t;
  typedef logic [7:0]  opc_cmd_t;
  typedef enum logic [1:0] {
    OPC_IDLE = 2'b00,
    OPC_SE0  = 2'b01
  } opc_se0_state_e;
endpackage
`default_nettype wire

/* File: logic/opc_sync_pulse.sv */
// rising-edge detector for a port event input
// assumes the event input is synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module opc_sync_pulse (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic level_in,
  output var  logic pulse_out
);
  logic last_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg  <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      last_reg  <= level_in;
      pulse_out <= level_in & ~last_reg;
    end
  end
endmodule
`default_nettype wire

/* File: logic/opc_port_control.sv */
// otg port control register and the port logic it steers
// assumes command strobes from the register port, events from the port transceiver
`timescale 1ns/1ns
`default_nettype none
`include "opc_regs.svh"
// Contract
// RL1 - with reset enable set, drive SE0 after a remote connect; else none
// RL2 - software clears pull-up, waits 50us, sets reset enable, picks host engine
// RL3 - A-device with srp detect enabled sets the srp detected flag on SRP
// RL4 - srp method select: 0 VBUS pulsing, 1 data line pulsing
// RL5 - engine select: 0 host engine, 1 peripheral engine on transceiver
// RL6 - dm pull-down control connects the DM pull-down when 1
// RL7 - dp pull-down control connects the DP pull-down when 1
// RL8 - A-device with auto connect sets DP pull-up on remote disconnect
// RL9 - software sets local connect before clearing auto connect
// RL10 - local connect drives the DP pull-up resistor
// RL11 - A-device source select: 0 charge pump, 1 external 5 V
// RL12 - with external source, host power switch follows vbus drive
// RL13 - vbus drive enables the selected source onto VBUS
// RL14 - register read with command 62, written with command e2
// RL15 - bits 15 to 12 read zero and ignore writes
module opc_port_control (
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            cmd_valid,
  input  wire opc_pkg::opc_cmd_t  cmd_code,
  input  wire opc_pkg::opc_word_t wr_data,
  input  wire logic            is_a_device,
  input  wire logic            remote_connect,
  input  wire logic            remote_disconnect,
  input  wire logic            vbus_pulse_seen,
  input  wire logic            data_pulse_seen,
  input  wire logic            srp_flag_clear,
  output var  opc_pkg::opc_word_t rd_data,
  output var  logic            rd_valid,
  output var  logic            drive_se0,
  output var  logic            srp_detected_flag,
  output var  logic            engine_select,
  output var  logic            dm_pulldown_on,
  output var  logic            dp_pulldown_on,
  output var  logic            dp_pullup_on,
  output var  logic            charge_pump_on,
  output var  logic            host_power_switch_out_n,
  output var  logic            vbus_discharge_on,
  output var  logic            vbus_charge_on
);
  import opc_pkg::*;

  opc_word_t      ctrl_reg;
  opc_se0_state_e se0_state_reg;
  logic [8:0]     se0_cnt_reg;
  logic           auto_up_reg;
  logic           conn_pulse;
  logic           disc_pulse;
  logic           wr_hit;
  logic           rd_hit;
  logic           srp_event;

  assign wr_hit = cmd_valid && (cmd_code == `OPC_CMD_WRITE); // [RL14]
  assign rd_hit = cmd_valid && (cmd_code == `OPC_CMD_READ);  // [RL14]

  opc_sync_pulse u_conn (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .level_in  (remote_connect),
    .pulse_out (conn_pulse)
  );

  opc_sync_pulse u_disc (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .level_in  (remote_disconnect),
    .pulse_out (disc_pulse)
  );

  // reserved bits never stored, so they read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `OPC_RESET_VALUE;
    end else if (wr_hit) begin
      ctrl_reg <= wr_data & `OPC_WRITE_MASK; // [RL15]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_hit;
      if (rd_hit) begin
        rd_data <= ctrl_reg & `OPC_WRITE_MASK; // [RL14] [RL15]
      end
    end
  end

  // se0 burst length is a chosen figure; a bus reset needs at least 10 us
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      se0_state_reg <= OPC_IDLE;
      se0_cnt_reg   <= 9'h000;
      drive_se0     <= 1'b0;
    end else begin
      case (se0_state_reg)
        OPC_IDLE: begin
          drive_se0 <= 1'b0;
          if (conn_pulse && ctrl_reg[`OPC_BIT_SE0_EN]) begin // [RL1]
            se0_state_reg <= OPC_SE0;
            se0_cnt_reg   <= 9'(`OPC_SE0_CYCLES - 1);
            drive_se0     <= 1'b1;
          end
        end
        OPC_SE0: begin
          if (se0_cnt_reg == 9'h000) begin
            se0_state_reg <= OPC_IDLE;
            drive_se0     <= 1'b0;
          end else begin
            se0_cnt_reg <= se0_cnt_reg - 9'h001;
          end
        end
        default: begin
          se0_state_reg <= OPC_IDLE;
          drive_se0     <= 1'b0;
        end
      endcase
    end
  end

  assign srp_event = ctrl_reg[`OPC_BIT_SRP_SEL] ? data_pulse_seen : vbus_pulse_seen; // [RL4]

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      srp_detected_flag <= 1'b0;
    end else if (is_a_device && ctrl_reg[`OPC_BIT_SRP_DET_EN] && srp_event) begin
      srp_detected_flag <= 1'b1; // [RL3]
    end else if (srp_flag_clear) begin
      srp_detected_flag <= 1'b0;
    end
  end

  // auto pull-up latched until the auto field or is_a_device is cleared
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      auto_up_reg <= 1'b0;
    end else if (!ctrl_reg[`OPC_BIT_AUTO_CONN] || !is_a_device) begin
      auto_up_reg <= 1'b0;
    end else if (disc_pulse) begin
      auto_up_reg <= 1'b1; // [RL8]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      engine_select           <= 1'b1;
      dm_pulldown_on          <= 1'b1;
      dp_pulldown_on          <= 1'b1;
      dp_pullup_on            <= 1'b0;
      charge_pump_on          <= 1'b0;
      host_power_switch_out_n <= 1'b1;
      vbus_discharge_on       <= 1'b0;
      vbus_charge_on          <= 1'b0;
    end else begin
      engine_select     <= ctrl_reg[`OPC_BIT_ENG_SEL]; // [RL5]
      dm_pulldown_on    <= ctrl_reg[`OPC_BIT_PD_DM];   // [RL6]
      dp_pulldown_on    <= ctrl_reg[`OPC_BIT_PD_DP];   // [RL7]
      dp_pullup_on      <= ctrl_reg[`OPC_BIT_LOCAL_DP_PULLUP] | auto_up_reg; // [RL10] [RL8]
      // only an A-device may source VBUS; gated here as a safety net
      charge_pump_on    <= is_a_device & ctrl_reg[`OPC_BIT_VBUS_DRIVE_ENABLE]
                           & ~ctrl_reg[`OPC_BIT_SRC_SEL]; // [RL11] [RL13]
      host_power_switch_out_n <= ~(is_a_device & ctrl_reg[`OPC_BIT_VBUS_DRIVE_ENABLE]
                                 & ctrl_reg[`OPC_BIT_SRC_SEL]); // [RL12] [RL13]
      vbus_discharge_on <= ~is_a_device & ctrl_reg[`OPC_BIT_DISCHRG];
      vbus_charge_on    <= ~is_a_device & ctrl_reg[`OPC_BIT_CHRG];
    end
  end

  property p_se0_on_connect;
    @(posedge mclk) disable iff (!rst_n)
      (conn_pulse && ctrl_reg[`OPC_BIT_SE0_EN] && se0_state_reg == OPC_IDLE) |=> drive_se0;
  endproperty
  a_se0_on_connect: assert property (p_se0_on_connect) else $error("no se0 after connect"); // [RL1]

  property p_no_se0_disabled;
    @(posedge mclk) disable iff (!rst_n)
      (se0_state_reg == OPC_IDLE && !(conn_pulse && ctrl_reg[`OPC_BIT_SE0_EN])) |=> !drive_se0;
  endproperty
  a_no_se0_disabled: assert property (p_no_se0_disabled) else $error("se0 without cause"); // [RL1]

  property p_srp_set;
    @(posedge mclk) disable iff (!rst_n)
      (is_a_device && ctrl_reg[`OPC_BIT_SRP_DET_EN] && srp_event) |=> srp_detected_flag;
  endproperty
  a_srp_set: assert property (p_srp_set) else $error("srp flag not set"); // [RL3]

  property p_srp_method;
    @(posedge mclk) disable iff (!rst_n)
      (!srp_detected_flag ##1 srp_detected_flag) |->
        $past(ctrl_reg[`OPC_BIT_SRP_SEL] ? data_pulse_seen : vbus_pulse_seen);
  endproperty
  a_srp_method: assert property (p_srp_method) else $error("srp set by wrong method"); // [RL4]

  property p_engine;
    @(posedge mclk) disable iff (!rst_n)
      wr_hit |=> ##1 (engine_select == $past(wr_data[`OPC_BIT_ENG_SEL], 2));
  endproperty
  a_engine: assert property (p_engine) else $error("engine select wrong"); // [RL5] [RL14]

  property p_pulldowns;
    @(posedge mclk) disable iff (!rst_n)
      ##1 (dm_pulldown_on == $past(ctrl_reg[`OPC_BIT_PD_DM])) &&
          (dp_pulldown_on == $past(ctrl_reg[`OPC_BIT_PD_DP]));
  endproperty
  a_pulldowns: assert property (p_pulldowns) else $error("pull-down mismatch"); // [RL6] [RL7]

  property p_auto_up;
    @(posedge mclk) disable iff (!rst_n)
      (disc_pulse && is_a_device && ctrl_reg[`OPC_BIT_AUTO_CONN]) |=> ##1 dp_pullup_on;
  endproperty
  a_auto_up: assert property (p_auto_up) else $error("no auto pull-up"); // [RL8]

  property p_local_conn;
    @(posedge mclk) disable iff (!rst_n)
      (!auto_up_reg && ctrl_reg[`OPC_BIT_LOCAL_DP_PULLUP] == 1'b0) |=> !dp_pullup_on;
  endproperty
  a_local_conn: assert property (p_local_conn) else $error("pull-up without cause"); // [RL10]

  property p_vbus_source;
    @(posedge mclk) disable iff (!rst_n)
      !(charge_pump_on && !host_power_switch_out_n);
  endproperty
  a_vbus_source: assert property (p_vbus_source) else $error("both vbus sources on"); // [RL11] [RL12] [RL13]

  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
      rd_valid |-> (rd_data[15:12] == 4'h0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // [RL15]

  c_se0: cover property (@(posedge mclk) disable iff (!rst_n) drive_se0 ##1 !drive_se0);
  c_srp: cover property (@(posedge mclk) disable iff (!rst_n) !srp_detected_flag ##1 srp_detected_flag);
  c_auto: cover property (@(posedge mclk) disable iff (!rst_n) auto_up_reg);
  c_ext: cover property (@(posedge mclk) disable iff (!rst_n) !host_power_switch_out_n);
endmodule
`default_nettype wire

/* File: verif/opc_remote_model.sv */
// remote device and transceiver model for the otg port control block
// assumes the bench raises one request bit per event and lowers it again
`timescale 1ns/1ns
`default_nettype none
module opc_remote_model (
  input  wire logic       mclk,
  input  wire logic [3:0] ev_req,
  output wire logic       remote_connect,
  output wire logic       remote_disconnect,
  output wire logic       vbus_pulse_seen,
  output wire logic       data_pulse_seen
);
  logic [3:0] lines_reg = 4'h0;

  // lines move only on an edge, like a transceiver already synchronised to mclk
  always @(posedge mclk) begin
    lines_reg <= ev_req;
  end
  assign {remote_connect, remote_disconnect, vbus_pulse_seen, data_pulse_seen} = lines_reg;
endmodule
`default_nettype wire

/* File: verif/tb_otg_port_control.sv */
// self-checking bench for the otg port control register block
// assumes the remote model drives the transceiver event lines
`timescale 1ns/1ns
`default_nettype none
`include "opc_regs.svh"
module tb_otg_port_control;
  import opc_pkg::*;
  logic      mclk = 1'b0;
  logic      rst_n = 1'b0;
  logic      cmd_valid = 1'b0;
  opc_cmd_t  cmd_code = 8'h00;
  opc_word_t wr_data = 16'h0000;
  logic      is_a_device = 1'b1;
  logic      srp_flag_clear = 1'b0;
  logic [3:0] ev_req = 4'h0;
  opc_word_t rd_data;
  logic      remote_connect, remote_disconnect, vbus_pulse_seen, data_pulse_seen;
  logic      rd_valid, drive_se0, srp_detected_flag, engine_select, dm_pulldown_on;
  logic      dp_pulldown_on, dp_pullup_on, charge_pump_on, host_power_switch_out_n;
  logic      vbus_discharge_on, vbus_charge_on;
  logic [3:0] pins;
  int        fails = 0;
  int        n_compared = 0;
  int        n;
  opc_word_t sw[5] = '{16'h0400, 16'h0400, 16'h0600, 16'h0600, 16'h0200};
  logic [3:0] ev[5] = '{4'h2, 4'h1, 4'h2, 4'h1, 4'h1};
  logic      fx[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  opc_remote_model remote (.mclk, .ev_req, .remote_connect, .remote_disconnect, .vbus_pulse_seen,
                           .data_pulse_seen);
  opc_port_control DUT (.mclk, .rst_n, .cmd_valid, .cmd_code, .wr_data, .is_a_device, .remote_connect,
                        .remote_disconnect, .vbus_pulse_seen, .data_pulse_seen, .srp_flag_clear,
                        .rd_data, .rd_valid, .drive_se0, .srp_detected_flag, .engine_select,
                        .dm_pulldown_on, .dp_pulldown_on, .dp_pullup_on, .charge_pump_on,
                        .host_power_switch_out_n, .vbus_discharge_on, .vbus_charge_on);
  always #10 mclk = ~mclk;
  task automatic cmpw(input opc_word_t g, input opc_word_t e, input string m);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cmpb(input logic g, input logic e, input string m);
    cmpw({15'h0000, g}, {15'h0000, e}, m);
  endtask
  task automatic cmd(input opc_cmd_t c, input opc_word_t d);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    wr_data <= d;
    @(posedge mclk);
    cmd_valid <= 1'b0;
  endtask
  task automatic wr(input opc_word_t d);
    cmd(`OPC_CMD_WRITE, d);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input opc_word_t e);
    cmd(`OPC_CMD_READ, 16'h0000);
    // read answer stands for one cycle only, so look right after the taking edge
    #1;
    cmpb(rd_valid, 1'b1, "rd_valid");
    cmpw(rd_data, e, "rd_data");
  endtask
  task automatic event_pulse(input logic [3:0] e);
    @(posedge mclk);
    ev_req <= e;
    @(posedge mclk);
    ev_req <= 4'h0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`OPC_RESET_VALUE);
    cmpb(host_power_switch_out_n, 1'b1, "switch idle");
    wr(16'hffff);
    rd(16'h0fff);
    cmd(8'he3, 16'h0000);
    rd(16'h0fff);
    $display("test regs done");
    for (int i = 0; i < 4; i++) begin
      wr(16'h0000);
      cmpb({engine_select, dm_pulldown_on, dp_pulldown_on, dp_pullup_on} != 4'h0, 1'b0, "pins off");
      wr(16'h0010 << (i == 0 ? 0 : i + 1));
      pins = {engine_select, dm_pulldown_on, dp_pulldown_on, dp_pullup_on};
      cmpb(pins[i], 1'b1, "pin on");
    end
    $display("test pins done");
    wr(16'h0001);
    cmpb(charge_pump_on, 1'b1, "pump");
    wr(16'h0009);
    cmpb(charge_pump_on, 1'b0, "pump ext");
    cmpb(host_power_switch_out_n, 1'b0, "switch on");
    wr(16'h0008);
    cmpb(host_power_switch_out_n, 1'b1, "switch off");
    $display("test vbus done");
    wr(16'h0000);
    repeat (2500) @(posedge mclk);
    wr(16'h0800);
    // connect raised by hand so the burst is counted from its first cycle
    @(posedge mclk);
    ev_req <= 4'h8;
    @(posedge mclk);
    ev_req <= 4'h0;
    #1;
    n = 0;
    while (drive_se0 !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n = 0;
    while (drive_se0 === 1'b1 && n < 600) begin
      @(posedge mclk);
      #1;
      n++;
    end
    cmpw(16'(n), 16'(`OPC_SE0_CYCLES), "se0 length");
    wr(16'h0000);
    event_pulse(4'h8);
    cmpb(drive_se0, 1'b0, "no se0");
    $display("test se0 done");
    for (int k = 0; k < 5; k++) begin
      wr(sw[k]);
      @(posedge mclk);
      srp_flag_clear <= 1'b1;
      @(posedge mclk);
      srp_flag_clear <= 1'b0;
      event_pulse(ev[k]);
      cmpb(srp_detected_flag, fx[k], "srp flag");
    end
    $display("test srp done");
    wr(16'h0000);
    event_pulse(4'h4);
    cmpb(dp_pullup_on, 1'b0, "no auto pullup");
    wr(16'h0020);
    event_pulse(4'h4);
    cmpb(dp_pullup_on, 1'b1, "auto pullup");
    wr(16'h0030);
    wr(16'h0010);
    cmpb(dp_pullup_on, 1'b1, "local pullup");
    $display("test auto connect done");
    @(posedge mclk);
    is_a_device <= 1'b0;
    wr(16'h0407);
    event_pulse(4'h2);
    cmpb(srp_detected_flag, 1'b0, "b-device srp");
    pins = {charge_pump_on, host_power_switch_out_n, vbus_discharge_on, vbus_charge_on};
    cmpw({12'h000, pins}, 16'h0007, "b-device vbus");
    $display("test b-device done");
    complete_run();
  end
endmodule
`default_nettype wire
